/* hw/arb_table_loader.sv */
// Purpose: Copies the arbitration table into the arbiter and tracks coherency
// Assumes: Load pulse and entry write strobe are on sys_clk
// Notes:   Copy lands on the edge that ends the load; table_active changes as load_busy falls
`timescale 1ns/10ps
module arb_table_loader
  import vc0_arb_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   ce,
  input  wire logic                   load_pulse,
  input  wire logic                   entry_write,
  input  wire logic [ARB_TABLE_W-1:0] table_in,
  output logic                        load_busy,
  output logic                        coherency_flag,
  output logic [ARB_TABLE_W-1:0]      table_active
);

  typedef struct packed {
    logic                   busy;
    logic [2:0]             cnt;
    logic                   flag;
    logic [ARB_TABLE_W-1:0] active;
  } loader_state_t;

  loader_state_t st_q;
  loader_state_t st_d;

  always_comb
  begin
    st_d = st_q;
    if (load_pulse && !st_q.busy)
    begin
      st_d.busy = 1'b1;
      st_d.cnt  = LOAD_CYCLES - 3'h1;
    end
    else if (st_q.busy)
    begin
      if (st_q.cnt == 3'h0)
      begin
        st_d.busy   = 1'b0;
        st_d.active = table_in;
        st_d.flag   = 1'b0;
      end
      else
      begin
        st_d.cnt = st_q.cnt - 3'h1;
      end
    end
    // Entry write wins over the clear at load end
    if (entry_write)
    begin
      st_d.flag = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st_q <= '0;
    end
    else if (ce)
    begin
      st_q <= st_d;
    end
  end

  assign load_busy      = st_q.busy;
  assign coherency_flag = st_q.flag;
  assign table_active   = st_q.active;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence busy_end_s;
    ce && st_q.busy && st_q.cnt == 3'h0 && !entry_write;
  endsequence

  a_flag_on_write: assert property (entry_write && ce |=> coherency_flag)
    else $error("coherency flag not set by entry write");
  a_flag_clear_load: assert property (busy_end_s |=> !coherency_flag)
    else $error("coherency flag not cleared after load");

endmodule : arb_table_loader

/* hw/vc0_arb_pkg.sv */
// Purpose: Constants for the VC0 port arbitration register bank
// Assumes: APB with 32-bit data, one word per register
// Notes:   Printed offsets are register indices; byte address is index times four
package vc0_arb_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [31:0] IDX_PORT_CHANNEL_STATUS  = 32'h0000_020e;
  localparam logic [31:0] IDX_CHANNEL0_RES_CAP     = 32'h0000_0210;
  localparam logic [31:0] IDX_CHANNEL0_RES_CTL     = 32'h0000_0214;
  localparam logic [31:0] IDX_TABLE_STATUS         = 32'h0000_0218;
  localparam logic [31:0] ADDR_PORT_CHANNEL_STATUS = IDX_PORT_CHANNEL_STATUS << 2;
  localparam logic [31:0] ADDR_CHANNEL0_RES_CAP    = IDX_CHANNEL0_RES_CAP << 2;
  localparam logic [31:0] ADDR_CHANNEL0_RES_CTL    = IDX_CHANNEL0_RES_CTL << 2;
  localparam logic [31:0] ADDR_TABLE_STATUS        = IDX_TABLE_STATUS << 2;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int TABLE_STATE_BIT   = 0;
  localparam int CAP_LSB           = 0;
  localparam int SNOOP_REJECT_BIT  = 15;
  localparam int MAX_SLOTS_LSB     = 16;
  localparam int TABLE_OFFSET_LSB  = 24;
  localparam int TC_MAP_LSB        = 0;
  localparam int LOAD_BIT          = 16;
  localparam int SELECT_LSB        = 17;
  localparam int CHANNEL_ID_LSB    = 24;
  localparam int CHANNEL_EN_BIT    = 31;
  localparam int COHERENCY_BIT     = 16;

  // ****************************************
  // Reset and fixed values
  // ****************************************
  localparam logic [15:0] PORT_STATUS_RESET  = 16'h0000;
  localparam logic [7:0]  PORT_ARB_CAP_RESET = 8'h01;
  localparam logic        SNOOP_REJECT_VAL   = 1'b0;
  localparam logic [6:0]  MAX_SLOTS_VAL      = 7'h00;
  localparam logic [7:0]  TABLE_OFFSET_RESET = 8'h04;
  localparam logic [7:0]  TC_MAP_RESET       = 8'hff;
  localparam logic [2:0]  SELECT_RESET       = 3'h0;
  localparam logic [2:0]  CHANNEL_ID_VAL     = 3'h0;
  localparam logic        CHANNEL_EN_VAL     = 1'b1;
  // Schemes that drive arbitration from the table (hardware fixed does not)
  localparam logic [7:0]  TABLE_SCHEMES      = 8'hfe;

  // ****************************************
  // Arbitration table and load timing
  // ****************************************
  localparam int          ARB_TABLE_W = 64;
  localparam logic [2:0]  LOAD_CYCLES = 3'h4;

endpackage : vc0_arb_pkg

/* hw/vc0_port_arbitration_regs.sv */
// Purpose: APB register bank for VC0 port arbitration control
// Assumes: APB master on sys_clk, table entries held outside this block
// Notes:   Access phase takes two cycles; pready is high for one cycle
//
// What this block does
// - Table state bit reads zero, read-only
// - Eight-bit capability field, resets to 0x1
// - Snoop reject bit reads zero
// - Maximum time slots field reads zero
// - Table offset in 16-byte units, value 0x4
// - Eight-bit traffic class map, resets all mapped
// - Class 0 map bit is read-only one
// - Writing load bit one copies table to arbiter
// - Writing load bit zero does nothing
// - Load bit always reads zero
// - Load acts only when scheme uses table
// - Three-bit writable arbitration scheme select
// - Channel identifier hardwired zero
// - Channel enable hardwired one
// - Entry write sets flag until load done
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
module vc0_port_arbitration_regs
  import vc0_arb_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   ce,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   table_entry_write,
  input  wire logic [ARB_TABLE_W-1:0] arb_table_in,
  output logic      [ARB_TABLE_W-1:0] arb_table_active,
  output logic      [7:0]             traffic_class_map,
  output logic      [2:0]             port_arb_select,
  output logic                        load_arb_table,
  output logic                        arb_table_coherency_flag,
  output logic                        load_busy
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    logic [7:1]  tc_map;
    logic [2:0]  select;
    logic        load_pulse;
  } regs_state_t;

  regs_state_t st_q;
  regs_state_t st_d;

  logic        access_wait;
  logic        access_fire;
  logic        wr_fire;
  logic        ctl_write;
  logic        table_used;
  logic        addr_hit;
  logic [31:0] rd_value;
  logic [2:0]  wr_select;

  // ****************************************
  // Read values
  // ****************************************
  function automatic logic [31:0] cap_word();
    logic [31:0] w;
    w = '0;
    w[CAP_LSB +: 8]          = PORT_ARB_CAP_RESET;
    w[SNOOP_REJECT_BIT]      = SNOOP_REJECT_VAL;
    w[MAX_SLOTS_LSB +: 7]    = MAX_SLOTS_VAL;
    w[TABLE_OFFSET_LSB +: 8] = TABLE_OFFSET_RESET;
    return w;
  endfunction : cap_word

  always_comb
  begin
    rd_value = '0;
    addr_hit = 1'b1;
    case (paddr)
      ADDR_PORT_CHANNEL_STATUS:
      begin
        rd_value[15:0] = PORT_STATUS_RESET;
      end
      ADDR_CHANNEL0_RES_CAP:
      begin
        rd_value = cap_word();
      end
      ADDR_CHANNEL0_RES_CTL:
      begin
        rd_value[TC_MAP_LSB +: 8]   = {st_q.tc_map, 1'b1};
        rd_value[LOAD_BIT]          = 1'b0;
        rd_value[SELECT_LSB +: 3]   = st_q.select;
        rd_value[CHANNEL_ID_LSB +: 3] = CHANNEL_ID_VAL;
        rd_value[CHANNEL_EN_BIT]    = CHANNEL_EN_VAL;
      end
      ADDR_TABLE_STATUS:
      begin
        rd_value[COHERENCY_BIT] = arb_table_coherency_flag;
      end
      default:
      begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Bus handshake and register writes
  // ****************************************
  assign access_wait = psel && penable && !st_q.ready;
  assign access_fire = psel && penable && st_q.ready;
  assign wr_fire     = access_fire && pwrite && !st_q.slverr;
  assign ctl_write   = wr_fire && (paddr == ADDR_CHANNEL0_RES_CTL);
  assign wr_select   = pwdata[SELECT_LSB +: 3];
  // Scheme chosen by this same write decides whether the load acts
  assign table_used  = TABLE_SCHEMES[wr_select];

  always_comb
  begin
    st_d            = st_q;
    st_d.load_pulse = 1'b0;
    if (access_wait)
    begin
      st_d.ready  = 1'b1;
      st_d.slverr = !addr_hit;
      st_d.rdata  = pwrite ? 32'h0000_0000 : rd_value;
    end
    else if (access_fire)
    begin
      st_d.ready  = 1'b0;
      st_d.slverr = 1'b0;
    end
    if (ctl_write)
    begin
      st_d.tc_map = pwdata[TC_MAP_LSB + 1 +: 7];
      st_d.select = wr_select;
      // Zero in the load bit neither starts nor cancels a load
      st_d.load_pulse = pwdata[LOAD_BIT] && table_used;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st_q.rdata      <= '0;
      st_q.ready      <= 1'b0;
      st_q.slverr     <= 1'b0;
      st_q.tc_map     <= TC_MAP_RESET[7:1];
      st_q.select     <= SELECT_RESET;
      st_q.load_pulse <= 1'b0;
    end
    else if (ce)
    begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // Table loader
  // ****************************************
  arb_table_loader u_loader (
    .sys_clk        (sys_clk),
    .sys_rst        (sys_rst),
    .ce             (ce),
    .load_pulse     (st_q.load_pulse),
    .entry_write    (table_entry_write),
    .table_in       (arb_table_in),
    .load_busy      (load_busy),
    .coherency_flag (arb_table_coherency_flag),
    .table_active   (arb_table_active)
  );

  assign prdata            = st_q.rdata;
  assign pready            = st_q.ready;
  assign pslverr           = st_q.slverr;
  assign traffic_class_map = {st_q.tc_map, 1'b1};
  assign port_arb_select   = st_q.select;
  assign load_arb_table    = st_q.load_pulse;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence rd_done_s(logic [31:0] a);
    pready && psel && penable && !pwrite && paddr == a;
  endsequence

  sequence load_req_s;
    ce && ctl_write && pwdata[LOAD_BIT];
  endsequence

  a_ready_follows: assert property (ce && access_wait |=> pready)
    else $error("pready not raised after access wait");
  a_ready_single: assert property (ce && pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_status_zero: assert property (rd_done_s(ADDR_PORT_CHANNEL_STATUS) |-> prdata == 32'h0000_0000)
    else $error("port channel status not zero");
  a_cap_low: assert property (rd_done_s(ADDR_CHANNEL0_RES_CAP) |-> prdata[7:0] == 8'h01)
    else $error("capability field wrong");
  a_snoop_zero: assert property (rd_done_s(ADDR_CHANNEL0_RES_CAP) |-> !prdata[15])
    else $error("snoop reject bit set");
  a_slots_zero: assert property (rd_done_s(ADDR_CHANNEL0_RES_CAP) |-> prdata[22:16] == 7'h00)
    else $error("max time slots not zero");
  a_offset_value: assert property (rd_done_s(ADDR_CHANNEL0_RES_CAP) |-> prdata[31:24] == 8'h04)
    else $error("table offset wrong");
  a_map_reads_back: assert property (rd_done_s(ADDR_CHANNEL0_RES_CTL) |-> prdata[7:0] == traffic_class_map)
    else $error("traffic class map read back wrong");
  a_class0_fixed: assert property (traffic_class_map[0])
    else $error("class 0 unmapped");
  a_map_write: assert property (ce && ctl_write |=> traffic_class_map == {$past(pwdata[7:1]), 1'b1})
    else $error("traffic class map not written");
  a_load_cause: assert property ($rose(load_arb_table) |-> $past(ctl_write && pwdata[LOAD_BIT] && table_used))
    else $error("load pulse without cause");
  a_load_zero_ignored: assert property (ce && ctl_write && !pwdata[LOAD_BIT] |=> !load_arb_table)
    else $error("load started by zero write");
  a_load_reads_zero: assert property (rd_done_s(ADDR_CHANNEL0_RES_CTL) |-> !prdata[16])
    else $error("load bit read as one");
  a_load_needs_table: assert property (load_req_s and !table_used |=> !load_arb_table)
    else $error("load acted without table scheme");
  a_select_write: assert property (ce && ctl_write |=> port_arb_select == $past(pwdata[19:17]))
    else $error("select not written");
  a_id_enable: assert property (rd_done_s(ADDR_CHANNEL0_RES_CTL) |-> prdata[31:24] == 8'h80)
    else $error("channel id or enable wrong");
  a_pulse_single: assert property (ce && load_arb_table |=> !load_arb_table)
    else $error("load pulse longer than one cycle");
  a_load_busy_next: assert property (ce && load_arb_table && !load_busy |=> load_busy)
    else $error("loader did not start");

  // ****************************************
  // Bus error and read data checks
  // ****************************************
  sequence bad_addr_s;
    ce && access_wait && !addr_hit;
  endsequence

  sequence good_addr_s;
    ce && access_wait && addr_hit;
  endsequence

  a_err_unmapped: assert property (bad_addr_s |=> pslverr && pready)
    else $error("unmapped access not flagged");
  a_err_clean: assert property (good_addr_s |=> !pslverr)
    else $error("error on mapped access");
  a_err_rdata_zero: assert property (bad_addr_s |=> prdata == 32'h0000_0000)
    else $error("read data not zero on error");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_wr_rdata_zero: assert property (ce && access_wait && pwrite |=> prdata == 32'h0000_0000)
    else $error("read data not cleared on write");
  a_rdata_hold: assert property (!(ce && access_wait) |=> $stable(prdata))
    else $error("read data changed outside decode");
  a_ready_cause: assert property ($rose(pready) |-> $past(access_wait))
    else $error("ready without access");

  // ****************************************
  // Clock enable freeze
  // ****************************************
  a_freeze_regs: assert property (!ce |=> $stable(traffic_class_map) && $stable(port_arb_select))
    else $error("registers moved with clock enable low");
  a_freeze_ready: assert property (!ce |=> $stable(pready) && $stable(pslverr))
    else $error("handshake moved with clock enable low");
  a_freeze_load: assert property (!ce |=> $stable(load_arb_table) && $stable(load_busy))
    else $error("load moved with clock enable low");
  a_freeze_flag: assert property (!ce |=> $stable(arb_table_coherency_flag))
    else $error("flag moved with clock enable low");

  // ****************************************
  // Field holds and reserved bits
  // ****************************************
  a_map_hold: assert property (ce && !ctl_write |=> $stable(traffic_class_map))
    else $error("traffic class map changed without write");
  a_select_hold: assert property (ce && !ctl_write |=> $stable(port_arb_select))
    else $error("select changed without write");
  a_load_from_one: assert property (load_req_s and table_used |=> load_arb_table)
    else $error("load pulse missing");
  a_no_load_idle: assert property (ce && !ctl_write |=> !load_arb_table)
    else $error("load pulse without write");
  a_busy_cause: assert property ($rose(load_busy) |-> $past(load_arb_table))
    else $error("loader started without pulse");
  a_cap_reserved: assert property (rd_done_s(ADDR_CHANNEL0_RES_CAP) |-> prdata[14:8] == 7'h00 && !prdata[23])
    else $error("capability reserved bits set");
  a_ctl_reserved: assert property (rd_done_s(ADDR_CHANNEL0_RES_CTL) |-> prdata[15:8] == 8'h00 && prdata[23:20] == 4'h0)
    else $error("control reserved bits set");
  a_ctl_class0: assert property (rd_done_s(ADDR_CHANNEL0_RES_CTL) |-> prdata[0])
    else $error("class 0 read as unmapped");
  a_table_status_rest: assert property (rd_done_s(ADDR_TABLE_STATUS) |-> prdata[15:0] == 16'h0000 && prdata[31:17] == 15'h0000)
    else $error("table status reserved bits set");

endmodule : vc0_port_arbitration_regs

/* testbench/tb_top.sv */
// Purpose: Self-checking bench for the VC0 port arbitration register bank
// Assumes: APB master driven by the bench, one clock, synchronous reset
// Notes:   Load timing follows the four-cycle loader of the design
`timescale 1ns/10ps
module tb_top
  import vc0_arb_pkg::*;
;
  localparam int LIMIT = 5000;
  logic                   sys_clk;
  logic                   sys_rst;
  logic                   ce;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [31:0]            paddr;
  logic [31:0]            pwdata;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   table_entry_write;
  logic [ARB_TABLE_W-1:0] arb_table_in;
  logic [ARB_TABLE_W-1:0] arb_table_active;
  logic [7:0]             traffic_class_map;
  logic [2:0]             port_arb_select;
  logic                   load_arb_table;
  logic                   arb_table_coherency_flag;
  logic                   load_busy;
  int                     failures;
  int                     n_tests;
  int                     cycles;
  int                     pulses;
  int                     p0;
  logic [31:0]            r;
  logic                   e;

  vc0_port_arbitration_regs i_vc0_port_arbitration_regs (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .table_entry_write(table_entry_write), .arb_table_in(arb_table_in),
    .arb_table_active(arb_table_active), .traffic_class_map(traffic_class_map),
    .port_arb_select(port_arb_select), .load_arb_table(load_arb_table),
    .arb_table_coherency_flag(arb_table_coherency_flag), .load_busy(load_busy)
  );

  // ****************************************
  // Clock, timeout and pulse counting
  // ****************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (load_arb_table === 1'b1) pulses <= pulses + 1;
    if (cycles == LIMIT)
    begin
      failures++;
      stop_test();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd_chk(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check({e, r}, {1'b0, exp});
  endtask : rd_chk

  task wait_load();
    int n;
    repeat (3) @(posedge sys_clk);
    n = 0;
    while (load_busy !== 1'b0 && n < 20)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 20) failures++;
  endtask : wait_load

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {ce, psel, penable, pwrite, table_entry_write} = 5'h10;
    {failures, n_tests, cycles, pulses} = '0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    arb_table_in = 64'h0123_4567_89ab_cdef;
    sys_rst = 1'b1;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd_chk(ADDR_PORT_CHANNEL_STATUS, 32'h0000_0000);
    rd_chk(ADDR_CHANNEL0_RES_CAP, 32'h0400_0001);
    rd_chk(ADDR_CHANNEL0_RES_CTL, 32'h8000_00ff);
    check(arb_table_active, 64'h0);
    // Read-only words ignore writes
    apb(1'b1, ADDR_CHANNEL0_RES_CAP, 32'hffff_ffff);
    rd_chk(ADDR_CHANNEL0_RES_CAP, 32'h0400_0001);
    apb(1'b1, ADDR_PORT_CHANNEL_STATUS, 32'hffff_ffff);
    rd_chk(ADDR_PORT_CHANNEL_STATUS, 32'h0000_0000);
    // Unmapped address answers with an error
    apb(1'b0, ADDR_CHANNEL0_RES_CAP + 32'h4, 32'h0);
    check({e, r}, {1'b1, 32'h0});
    // Class 0 stays mapped; only the advertised scheme 0 is selected
    apb(1'b1, ADDR_CHANNEL0_RES_CTL, 32'h0000_0000);
    rd_chk(ADDR_CHANNEL0_RES_CTL, 32'h8000_0001);
    check(traffic_class_map, 8'h01);
    // Entry write marks the table stale
    @(posedge sys_clk) table_entry_write <= 1'b1;
    @(posedge sys_clk) table_entry_write <= 1'b0;
    rd_chk(ADDR_TABLE_STATUS, 32'h0001_0000);
    // Load with hardware fixed scheme does nothing
    p0 = pulses;
    apb(1'b1, ADDR_CHANNEL0_RES_CTL, 32'h0001_005a);
    wait_load();
    check(pulses - p0, 0);
    check(arb_table_coherency_flag, 1'b1);
    rd_chk(ADDR_CHANNEL0_RES_CTL, 32'h8000_005b);
    // Writing zero to the load bit
    apb(1'b1, ADDR_CHANNEL0_RES_CTL, 32'h0002_00a4);
    wait_load();
    check(pulses - p0, 0);
    check({arb_table_coherency_flag, port_arb_select}, {1'b1, 3'h1});
    rd_chk(ADDR_CHANNEL0_RES_CTL, 32'h8002_00a5);
    // Real load with a table scheme
    apb(1'b1, ADDR_CHANNEL0_RES_CTL, 32'h0003_00a4);
    wait_load();
    check(pulses - p0, 1);
    check(arb_table_active, 64'h0123_4567_89ab_cdef);
    rd_chk(ADDR_TABLE_STATUS, 32'h0000_0000);
    rd_chk(ADDR_CHANNEL0_RES_CTL, 32'h8002_00a5);
    // Clock enable low freezes the flag
    @(posedge sys_clk)
    begin
      ce <= 1'b0;
      table_entry_write <= 1'b1;
    end
    @(posedge sys_clk) table_entry_write <= 1'b0;
    @(posedge sys_clk) ce <= 1'b1;
    check(arb_table_coherency_flag, 1'b0);
    // Every select value reads back
    for (int s = 0; s < 8; s++)
    begin
      apb(1'b1, ADDR_CHANNEL0_RES_CTL, {12'h000, s[2:0], 17'h000ff});
      rd_chk(ADDR_CHANNEL0_RES_CTL, {12'h800, s[2:0], 17'h000ff});
    end
    // Second reset in mid-run
    @(posedge sys_clk) sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd_chk(ADDR_CHANNEL0_RES_CTL, 32'h8000_00ff);
    check(arb_table_active, 64'h0);
    check({load_busy, arb_table_coherency_flag, load_arb_table, port_arb_select}, 6'h00);
    stop_test();
  end

endmodule : tb_top
